// [hdl/fpc_top.sv]
// Fan pulse-count and miscellaneous configuration bank with its consumers.
// Assumes a same-clock register port; fan and pin inputs are asynchronous.
//
// What this block does
// - Bits 1:0 set fan one pulse count
// - Bits 3:2 set fan two pulse count
// - Bits 5:4 set fan three pulse count
// - Bits 7:6 set fan four pulse count
// - Pulse-count register resets to 0x55
// - Bit 0 picks two's complement or offset-64
// - Format change reinterprets stored temperatures at once
// - Bit 1 picks high or low drive band
// - Bit 2 sets general pin direction
// - Bit 3 sets general pin output polarity
// - Lock makes fifth configuration register read-only
// - Fifth register resets zero; upper bits plain storage
// - General pin drives only with function code 11; its level reads back under any code
`timescale 1ns/10ps
module fpc_top (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [fpc_pkg::NUM_FANS-1:0] speed_sense_i,
  output logic [fpc_pkg::NUM_FANS*fpc_pkg::PERIOD_W-1:0] fan_period_o,
  output logic [fpc_pkg::NUM_FANS-1:0] fan_done_o,
  output logic drive_frequency_band_o,
  input wire logic [7:0] temp_reading_i,
  input wire logic [7:0] temp_limit_i,
  output logic signed [8:0] temp_reading_o,
  output logic signed [8:0] temp_limit_o,
  output logic temp_over_limit_o,
  input wire logic gp_assert_i,
  input wire logic gp_pin_i,
  output logic gp_pin_o,
  output logic gp_pin_oe_o
);
  logic [7:0] pulse_r;
  logic [7:0] cfg5_r;
  logic [7:0] cfg1_r;
  logic [7:0] cfg4_r;
  logic [7:0] rdata_nxt;
  logic [15:0] tick_cnt_r;
  logic tick_r;
  logic lock;
  logic gp_enable;
  logic gp_level;
  logic wr_pulse;
  logic wr_cfg5;
  logic wr_cfg1;
  logic wr_cfg4;
  logic [fpc_pkg::NUM_FANS-1:0] sense_meta_r;
  logic [fpc_pkg::NUM_FANS-1:0] sense_sync_r;
  logic [fpc_pkg::NUM_FANS*fpc_pkg::PERIOD_W-1:0] period_flat;
  logic [fpc_pkg::NUM_FANS-1:0] done_flat;
  logic signed [8:0] reading_dec;
  logic signed [8:0] limit_dec;

  localparam logic [15:0] TICK_LAST = 16'(fpc_pkg::TICK_CYC - 1);

  assign lock = cfg1_r[fpc_pkg::CFG1_LOCK_BIT];
  assign gp_enable = (cfg4_r[fpc_pkg::CFG4_PINF_LSB +: 2] ==
                      fpc_pkg::PINF_GENERAL);
  assign wr_pulse = reg_wr_i && (reg_addr_i == fpc_pkg::ADDR_PULSE);
  assign wr_cfg5 = reg_wr_i && (reg_addr_i == fpc_pkg::ADDR_CFG5);
  assign wr_cfg1 = reg_wr_i && (reg_addr_i == fpc_pkg::ADDR_CFG1);
  assign wr_cfg4 = reg_wr_i && (reg_addr_i == fpc_pkg::ADDR_CFG4);

  // Register storage

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_r <= fpc_pkg::PULSE_RST;
    end else if (wr_pulse) begin
      pulse_r <= reg_wdata_i;
    end
  end

  // Upper nibble has no consumer but stays read/write
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg5_r <= fpc_pkg::CFG5_RST;
    end else if (wr_cfg5 && !lock) begin
      cfg5_r <= reg_wdata_i;
    end
  end

  // Lock can only be released by reset, so a stray write cannot undo it
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg1_r <= fpc_pkg::CFG1_RST;
    end else if (wr_cfg1) begin
      cfg1_r <= reg_wdata_i;
      cfg1_r[fpc_pkg::CFG1_LOCK_BIT] <=
        lock | reg_wdata_i[fpc_pkg::CFG1_LOCK_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg4_r <= fpc_pkg::CFG4_RST;
    end else if (wr_cfg4 && !lock) begin
      cfg4_r <= reg_wdata_i;
    end
  end

  // Read path

  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_addr_i[7:3] == fpc_pkg::ADDR_PERIOD_BASE[7:3]) begin
      rdata_nxt = period_flat[{reg_addr_i[2:1], reg_addr_i[0], 3'h0} +: 8];
    end else begin
      unique case (reg_addr_i)
        fpc_pkg::ADDR_PULSE: begin
          rdata_nxt = pulse_r;
        end
        fpc_pkg::ADDR_CFG5: begin
          rdata_nxt = cfg5_r;
        end
        fpc_pkg::ADDR_CFG1: begin
          rdata_nxt = cfg1_r;
        end
        fpc_pkg::ADDR_CFG4: begin
          rdata_nxt = cfg4_r;
        end
        fpc_pkg::ADDR_STATUS: begin
          rdata_nxt[fpc_pkg::STAT_LEVEL_BIT] = gp_level;
          rdata_nxt[fpc_pkg::STAT_LOCK_BIT] = lock;
        end
        default: begin
          rdata_nxt = 8'h00;
        end
      endcase
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rdata_nxt;
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // Measurement timebase

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == TICK_LAST) begin
      tick_cnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end

  // Fan sense synchronisers; only the second stage feeds the engines
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_meta_r <= '0;
      sense_sync_r <= '0;
    end else begin
      sense_meta_r <= speed_sense_i;
      sense_sync_r <= sense_meta_r;
    end
  end

  // Fan i takes its count from bits 2i+1:2i of the pulse-count register
  genvar gi;
  generate
    for (gi = 0; gi < fpc_pkg::NUM_FANS; gi++) begin : g_fan
      fpc_meas_if mif ();
      assign mif.tick = tick_r;
      assign mif.sense = sense_sync_r[gi];
      assign mif.code = pulse_r[2*gi +: 2];
      assign period_flat[gi*fpc_pkg::PERIOD_W +: fpc_pkg::PERIOD_W] =
        mif.period;
      assign done_flat[gi] = mif.done;
      fpc_speed_sense_input_meas u_meas (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .m(mif.meas)
      );
    end
  endgenerate

  // Registered copies keep top outputs straight from flops
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fan_period_o <= '0;
      fan_done_o <= '0;
    end else begin
      fan_period_o <= period_flat;
      fan_done_o <= done_flat;
    end
  end

  // Drive band

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      drive_frequency_band_o <= 1'b0;
    end else begin
      drive_frequency_band_o <= cfg5_r[fpc_pkg::CFG5_BAND_BIT];
    end
  end

  // Temperature interpretation; decoding follows the live format bit,
  // so stored codes are never rewritten when the format changes

  assign reading_dec = fpc_pkg::fpc_temp_decode(temp_reading_i,
                         cfg5_r[fpc_pkg::CFG5_FMT_BIT]);
  assign limit_dec = fpc_pkg::fpc_temp_decode(temp_limit_i,
                       cfg5_r[fpc_pkg::CFG5_FMT_BIT]);

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      temp_reading_o <= 9'sh000;
      temp_limit_o <= 9'sh000;
      temp_over_limit_o <= 1'b0;
    end else begin
      temp_reading_o <= reading_dec;
      temp_limit_o <= limit_dec;
      temp_over_limit_o <= (reading_dec > limit_dec);
    end
  end

  // General-purpose pin

  fpc_gpin u_gpin (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .gp_enable_i(gp_enable),
    .general_pin_direction_i(cfg5_r[fpc_pkg::CFG5_DIR_BIT]),
    .general_pin_polarity_i(cfg5_r[fpc_pkg::CFG5_POL_BIT]),
    .gp_assert_i(gp_assert_i),
    .gp_pin_i(gp_pin_i),
    .gp_pin_o(gp_pin_o),
    .gp_pin_oe_o(gp_pin_oe_o),
    .gp_level_o(gp_level)
  );

  // Checks

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_cfg5_locked_write;
    wr_cfg5 && lock;
  endsequence

  sequence s_cfg5_open_write;
    wr_cfg5 && !lock;
  endsequence

  sequence s_fmt_flip;
    wr_cfg5 && !lock &&
      (reg_wdata_i[fpc_pkg::CFG5_FMT_BIT] != cfg5_r[fpc_pkg::CFG5_FMT_BIT]);
  endsequence

  property p_lock_blocks;
    s_cfg5_locked_write |=> $stable(cfg5_r);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("locked register accepted a write");

  property p_lock_sticky;
    lock |=> lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock released without reset");

  property p_cfg5_store;
    s_cfg5_open_write |=>
      (cfg5_r == $past(reg_wdata_i));
  endproperty
  a_cfg5_store: assert property (p_cfg5_store)
    else $error("fifth register write not stored whole");

  property p_cfg5_read;
    (reg_rd_i && (reg_addr_i == fpc_pkg::ADDR_CFG5)) |=>
      (reg_rdata_o == $past(cfg5_r));
  endproperty
  a_cfg5_read: assert property (p_cfg5_read)
    else $error("fifth register read mismatch");

  property p_pulse_read;
    (reg_rd_i && (reg_addr_i == fpc_pkg::ADDR_PULSE)) |=>
      (reg_rdata_o == $past(pulse_r));
  endproperty
  a_pulse_read: assert property (p_pulse_read)
    else $error("pulse-count read mismatch");

  property p_band_follow;
    s_cfg5_open_write ##2 1'b1 |->
      (drive_frequency_band_o == $past(reg_wdata_i[1], 2));
  endproperty
  a_band_follow: assert property (p_band_follow)
    else $error("drive band did not follow register");

  property p_fmt_switch;
    s_fmt_flip ##2 1'b1 |->
      (temp_reading_o == fpc_pkg::fpc_temp_decode($past(temp_reading_i),
         $past(reg_wdata_i[0], 2)));
  endproperty
  a_fmt_switch: assert property (p_fmt_switch)
    else $error("temperature not reinterpreted after format change");

  property p_pin_direction;
    ##1 (gp_pin_oe_o == ($past(gp_enable) &&
      $past(cfg5_r[fpc_pkg::CFG5_DIR_BIT])));
  endproperty
  a_pin_direction: assert property (p_pin_direction)
    else $error("pin enable does not match function and direction");

  property p_pin_polarity;
    gp_pin_oe_o |-> (gp_pin_o == ($past(cfg5_r[fpc_pkg::CFG5_POL_BIT]) ?
      $past(gp_assert_i) : !$past(gp_assert_i)));
  endproperty
  a_pin_polarity: assert property (p_pin_polarity)
    else $error("pin output polarity wrong");
endmodule

// [hdl/fpc_pkg.sv]
// Shared constants for the fan pulse-count and configuration bank.
// Assumes an 8-bit register port and a single 250 MHz system clock.
package fpc_pkg;
  localparam logic [7:0] ADDR_CFG1 = 8'h40;
  localparam logic [7:0] ADDR_STATUS = 8'h41;
  localparam logic [7:0] ADDR_PERIOD_BASE = 8'h30;
  localparam logic [7:0] ADDR_PULSE = 8'h7b;
  localparam logic [7:0] ADDR_CFG5 = 8'h7c;
  localparam logic [7:0] ADDR_CFG4 = 8'h7d;
  localparam logic [7:0] PULSE_RST = 8'h55;
  localparam logic [7:0] CFG5_RST = 8'h00;
  localparam logic [7:0] CFG1_RST = 8'h00;
  localparam logic [7:0] CFG4_RST = 8'h00;
  localparam int CFG1_LOCK_BIT = 1;
  localparam int CFG5_FMT_BIT = 0;
  localparam int CFG5_BAND_BIT = 1;
  localparam int CFG5_DIR_BIT = 2;
  localparam int CFG5_POL_BIT = 3;
  localparam int CFG4_PINF_LSB = 0;
  localparam logic [1:0] PINF_GENERAL = 2'h3;
  localparam int STAT_LEVEL_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int NUM_FANS = 4;
  localparam int CODE_W = 2;
  localparam int PERIOD_W = 16;
  localparam logic signed [8:0] TEMP_OFFSET = 9'sh040;
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_PERIOD_NS = 10000;
  localparam int TICK_CYC = TICK_PERIOD_NS / CLK_PERIOD_NS;

  typedef enum logic {
    FPC_ARM = 1'b0,
    FPC_COUNT = 1'b1
  } fpc_meas_state_e;

  function automatic logic signed [8:0] fpc_temp_decode(
    input logic [7:0] raw,
    input logic twos
  );
    logic signed [8:0] v;
    v = twos ? $signed({raw[7], raw}) : ($signed({1'b0, raw}) - TEMP_OFFSET);
    return v;
  endfunction
endpackage

// [hdl/fpc_meas_if.sv]
// Carrier between the bank and one fan measurement engine.
// Assumes both ends share clk_sys_i.
`timescale 1ns/10ps
interface fpc_meas_if;
  logic tick;
  logic sense;
  logic [fpc_pkg::CODE_W-1:0] code;
  logic [fpc_pkg::PERIOD_W-1:0] period;
  logic done;
  modport ctrl(output tick, output sense, output code,
               input period, input done);
  modport meas(input tick, input sense, input code,
               output period, output done);
endinterface

// [hdl/fpc_speed_sense_input_meas.sv]
// One fan speed measurement engine: times the span of N sense pulses.
// Assumes sense is already synchronised and tick is a one-cycle enable.
`timescale 1ns/10ps
module fpc_speed_sense_input_meas (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  fpc_meas_if.meas m
);
  fpc_pkg::fpc_meas_state_e state_r;
  logic sense_d_r;
  logic [2:0] target_r;
  logic [2:0] edges_r;
  logic [fpc_pkg::PERIOD_W-1:0] cnt_r;
  logic [fpc_pkg::PERIOD_W-1:0] period_r;
  logic done_r;
  logic rise;
  logic start;
  logic last_edge;
  logic stalled;

  assign rise = m.sense & ~sense_d_r;
  assign last_edge = (state_r == fpc_pkg::FPC_COUNT) && rise &&
                     ((edges_r + 3'h1) == target_r);
  assign start = rise && ((state_r == fpc_pkg::FPC_ARM) || last_edge);
  assign stalled = (state_r == fpc_pkg::FPC_COUNT) && m.tick && (&cnt_r) &&
                   !last_edge;
  assign m.period = period_r;
  assign m.done = done_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sense_d_r <= 1'b0;
    end else begin
      sense_d_r <= m.sense;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= fpc_pkg::FPC_ARM;
    end else begin
      unique case (state_r)
        fpc_pkg::FPC_ARM: begin
          if (rise) begin
            state_r <= fpc_pkg::FPC_COUNT;
          end
        end
        fpc_pkg::FPC_COUNT: begin
          // A stopped fan would otherwise hold the engine forever
          if (stalled) begin
            state_r <= fpc_pkg::FPC_ARM;
          end
        end
      endcase
    end
  end

  // Code is sampled only at the opening edge of a span
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      target_r <= 3'h2;
      edges_r <= 3'h0;
    end else if (start) begin
      target_r <= {1'b0, m.code} + 3'h1;
      edges_r <= 3'h0;
    end else if ((state_r == fpc_pkg::FPC_COUNT) && rise) begin
      edges_r <= edges_r + 3'h1;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
    end else if (start) begin
      cnt_r <= '0;
    end else if ((state_r == fpc_pkg::FPC_COUNT) && m.tick && !(&cnt_r)) begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      period_r <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= last_edge || stalled;
      if (last_edge || stalled) begin
        period_r <= cnt_r;
      end
    end
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_span_open;
    rise && (state_r == fpc_pkg::FPC_ARM);
  endsequence

  property p_target_load;
    s_span_open |=> (target_r == {1'b0, $past(m.code)} + 3'h1);
  endproperty
  a_target_load: assert property (p_target_load)
    else $error("pulse target not loaded from code");

  property p_span_close;
    last_edge |=> done_r && (period_r == $past(cnt_r)) && (cnt_r == '0);
  endproperty
  a_span_close: assert property (p_span_close)
    else $error("span end did not publish period");
endmodule

// [hdl/fpc_gpin.sv]
// General-purpose pin driver: direction, polarity and input sampling.
// Assumes the pad resolves the wire from gp_pin_oe_o.
`timescale 1ns/10ps
module fpc_gpin (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic gp_enable_i,
  input wire logic general_pin_direction_i,
  input wire logic general_pin_polarity_i,
  input wire logic gp_assert_i,
  input wire logic gp_pin_i,
  output logic gp_pin_o,
  output logic gp_pin_oe_o,
  output logic gp_level_o
);
  logic pin_meta_r;
  logic pin_sync_r;
  logic drive;

  assign drive = gp_enable_i && general_pin_direction_i;
  assign gp_level_o = pin_sync_r;

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
    end else begin
      pin_meta_r <= gp_pin_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gp_pin_oe_o <= 1'b0;
      gp_pin_o <= 1'b0;
    end else begin
      gp_pin_oe_o <= drive;
      if (drive) begin
        gp_pin_o <= general_pin_polarity_i ? gp_assert_i : ~gp_assert_i;
      end else begin
        gp_pin_o <= 1'b0;
      end
    end
  end
endmodule

// [bench/fpc_fan_model.sv]
// Far-side model: four fans giving sense pulses and the general pin pad.
// Assumes the pad is pulled to ext_level_i whenever the block releases it.
`timescale 1ns/10ps
module fpc_fan_model #(
  parameter int HALF_CYC = 2500
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic gp_pin_o,
  input wire logic gp_pin_oe_o,
  input wire logic ext_level_i,
  output logic [3:0] speed_sense_o,
  output logic gp_pin_i
);
  int cnt_r;

  // All fans share one rate; the pulse-count codes tell them apart
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 0;
      speed_sense_o <= 4'h0;
    end else if (cnt_r == HALF_CYC - 1) begin
      cnt_r <= 0;
      speed_sense_o <= ~speed_sense_o;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end

  // Wire level: block drives when enabled, else the external source
  assign gp_pin_i = gp_pin_oe_o ? gp_pin_o : ext_level_i;
endmodule

// [bench/fpc_top_tb.sv]
// Self-checking bench for the fan pulse-count and configuration bank.
// Assumes the register port answers reads one cycle after the strobe.
`timescale 1ns/10ps
module fpc_top_tb;
  localparam int HALF = 2500;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [7:0] reg_rdata_o;
  logic [3:0] speed_sense_i;
  logic [63:0] fan_period_o;
  logic [3:0] fan_done_o;
  logic drive_frequency_band_o;
  logic [7:0] temp_reading_i = 8'hf0;
  logic [7:0] temp_limit_i = 8'h10;
  logic signed [8:0] temp_reading_o;
  logic signed [8:0] temp_limit_o;
  logic temp_over_limit_o;
  logic gp_assert_i = 1'b0;
  logic gp_pin_i;
  logic gp_pin_o;
  logic gp_pin_oe_o;
  logic ext_level = 1'b1;
  int n_fail = 0;
  int tests_run = 0;
  logic [7:0] rd;

  initial begin
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  fpc_top dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .speed_sense_i(speed_sense_i), .fan_period_o(fan_period_o),
    .fan_done_o(fan_done_o),
    .drive_frequency_band_o(drive_frequency_band_o),
    .temp_reading_i(temp_reading_i), .temp_limit_i(temp_limit_i),
    .temp_reading_o(temp_reading_o), .temp_limit_o(temp_limit_o),
    .temp_over_limit_o(temp_over_limit_o), .gp_assert_i(gp_assert_i),
    .gp_pin_i(gp_pin_i), .gp_pin_o(gp_pin_o), .gp_pin_oe_o(gp_pin_oe_o));

  fpc_fan_model #(.HALF_CYC(HALF)) fans (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .gp_pin_o(gp_pin_o), .gp_pin_oe_o(gp_pin_oe_o),
    .ext_level_i(ext_level), .speed_sense_o(speed_sense_i),
    .gp_pin_i(gp_pin_i));

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask

  task automatic read_check(input string name, input logic [7:0] a,
                            input logic [7:0] exp);
    logic [7:0] v;
    reg_read(a, v);
    check(name, v, exp);
  endtask

  // Outputs that follow the registers lag by one cycle; two are allowed
  task automatic settle();
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(4 * 80000);
    n_fail++;
    final_report();
  end

  initial begin
    int cnt[4];
    int e;
    logic [15:0] p;
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    read_check("pulse_rst", fpc_pkg::ADDR_PULSE, 8'h55);
    read_check("cfg5_rst", fpc_pkg::ADDR_CFG5, 8'h00);
    read_check("unmapped", 8'h20, 8'h00);
    read_check("pin_in", fpc_pkg::ADDR_STATUS, 8'h01);
    check("oe_default", gp_pin_oe_o, 1'b0);
    reg_write(fpc_pkg::ADDR_PULSE, 8'he4);
    read_check("pulse_rw", fpc_pkg::ADDR_PULSE, 8'he4);
    reg_write(fpc_pkg::ADDR_CFG5, 8'hf0);
    read_check("cfg5_upper", fpc_pkg::ADDR_CFG5, 8'hf0);
    settle();
    // Raw 0xf0 and 0x10 read very differently in the two formats
    check("rd_off64", temp_reading_o, 9'sd176);
    check("lim_off64", temp_limit_o, -9'sd48);
    check("over_off64", temp_over_limit_o, 1'b1);
    check("band_hi", drive_frequency_band_o, 1'b0);
    reg_write(fpc_pkg::ADDR_CFG5, 8'h01);
    settle();
    check("rd_twos", temp_reading_o, -9'sd16);
    check("lim_twos", temp_limit_o, 9'sd16);
    check("over_twos", temp_over_limit_o, 1'b0);
    reg_write(fpc_pkg::ADDR_CFG5, 8'h02);
    settle();
    check("band_lo", drive_frequency_band_o, 1'b1);
    reg_write(fpc_pkg::ADDR_CFG5, 8'h04);
    settle();
    check("oe_no_func", gp_pin_oe_o, 1'b0);
    reg_write(fpc_pkg::ADDR_CFG4, 8'h03);
    reg_write(fpc_pkg::ADDR_CFG5, 8'h00);
    settle();
    check("oe_input", gp_pin_oe_o, 1'b0);
    for (int pol = 0; pol < 2; pol++) begin
      reg_write(fpc_pkg::ADDR_CFG5, pol ? 8'h0c : 8'h04);
      for (int a = 0; a < 2; a++) begin
        @(posedge clk_sys_i);
        gp_assert_i <= a[0];
        settle();
        check("oe_out", gp_pin_oe_o, 1'b1);
        check("pin_val", gp_pin_o, pol ? a[0] : !a[0]);
      end
    end
    // Wait until every fan has reported twice so the span opened before the code
    // write cannot be the one measured
    cnt = '{0, 0, 0, 0};
    for (int t = 0; t < 60000; t++) begin
      @(posedge clk_sys_i);
      #1;
      for (int i = 0; i < 4; i++) begin
        if (fan_done_o[i] === 1'b1) cnt[i]++;
      end
      if (cnt[0] > 1 && cnt[1] > 1 && cnt[2] > 1 && cnt[3] > 1) break;
    end
    // A fan that never reports twice must not slip through as a pass
    check("fan_results", (cnt[0] > 1) && (cnt[1] > 1) && (cnt[2] > 1) &&
          (cnt[3] > 1), 1'b1);
    for (int i = 0; i < 4; i++) begin
      e = (i + 1) * 2 * HALF / fpc_pkg::TICK_CYC;
      p = fan_period_o[16*i +: 16];
      // Tick phase against the pulses is free, so one tick either way
      check("fan_span", (p >= e - 1) && (p <= e + 1), 1'b1);
    end
    reg_read(fpc_pkg::ADDR_PERIOD_BASE, rd);
    check("period_lo", (rd >= 8'h01) && (rd <= 8'h03), 1'b1);
    read_check("period_hi", fpc_pkg::ADDR_PERIOD_BASE + 8'h01, 8'h00);
    reg_write(fpc_pkg::ADDR_CFG1, 8'h02);
    reg_write(fpc_pkg::ADDR_CFG5, 8'h33);
    read_check("locked", fpc_pkg::ADDR_CFG5, 8'h0c);
    reg_write(fpc_pkg::ADDR_CFG1, 8'h00);
    reg_write(fpc_pkg::ADDR_CFG5, 8'h00);
    read_check("still_lock", fpc_pkg::ADDR_CFG5, 8'h0c);
    reg_read(fpc_pkg::ADDR_STATUS, rd);
    check("lock_flag", rd[1], 1'b1);
    settle();
    check("oe_kept", gp_pin_oe_o, 1'b1);
    final_report();
  end
endmodule
